// ===== inc/epg_pkg.sv
`default_nettype none
package epg_pkg;
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFS_PE_EN_LO = 12'h000;
	localparam logic [11:0] OFS_PE_EN_HI = 12'h004;
	localparam logic [11:0] OFS_MODE_ENTRY = 12'h008;
	localparam logic [11:0] OFS_BC_CTRL = 12'h00c;
	localparam logic [11:0] OFS_BC_RESULT = 12'h010;
	localparam logic [11:0] OFS_MAT_SEL = 12'h014;
	localparam logic [7:0] KEY_PE_EN_LO = 8'h1e;
	localparam logic [7:0] KEY_PE_EN_HI = 8'he1;
	localparam logic [7:0] KEY_MODE_ENTRY = 8'haa;
	localparam logic [7:0] KEY_MAT_SEL = 8'hb3;
	localparam int KEY_POS = 8;
	localparam int EEPROM_PE_SELECT_POS = 7;
	localparam int BC_OFFSET_LSB = 3;
	localparam int BC_OFFSET_MSB = 12;
	localparam int BC_SIZE_POS = 0;
	localparam int BC_SHIFT = 3;
	localparam int NOT_BLANK_POS = 0;
	localparam int INFO_SEL_POS = 0;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [9:0] RST_BC_OFFSET = 10'h000;
	localparam logic [7:0] MODE_IDLE = 8'h00;
	localparam logic [7:0] MODE_ROM_0 = 8'h01;
	localparam logic [7:0] MODE_ROM_1 = 8'h02;
	localparam logic [7:0] MODE_ROM_2 = 8'h04;
	localparam logic [7:0] MODE_ROM_3 = 8'h08;
	localparam logic [7:0] MODE_ROM_4 = 8'h10;
	localparam logic [7:0] MODE_ROM_5 = 8'h20;
	localparam logic [7:0] MODE_EEPROM = 8'h80;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
		logic [3:0] pstrb;
	} epg_apb_req_s;

	typedef struct packed {
		logic valid;
		logic isPe;
		logic [3:0] block;
		logic [31:0] blockBase;
	} epg_cmd_s;
endpackage
`default_nettype wire

// ===== hw/epg_regs.sv
// Implementation choices: the APB register port and the register offsets.
`default_nettype none
module epg_regs (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire epg_pkg::epg_apb_req_s apbReq,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic romEnabledPin,
	input wire logic standbyPin,
	input wire logic controllerReadyFlag,
	input wire logic controllerSoftReset,
	input wire logic blankCheckDone,
	input wire logic blankCheckNotBlank,
	input wire epg_pkg::epg_cmd_s peCmd,
	output logic [15:0] blockPeAllow,
	output logic eepromPeSelect,
	output logic [6:0] romPeSelect,
	output logic illegalCommandError,
	output logic commandLocked,
	output logic blankCheckSize,
	output logic [31:0] blankCheckStart,
	output logic infoAreaSelect,
	output logic peGrant,
	output logic peProtectError
);
	import epg_pkg::*;

	logic [2:0] romSync;
	logic [2:0] stbySync;
	logic romEnabled;
	logic standby;
	logic [7:0] peEnLo;
	logic [7:0] peEnHi;
	logic [7:0] modeEntry;
	logic [9:0] bcOffset;
	logic blank_check_size;
	logic notBlank;
	logic infoSel;
	logic accessCycle;
	logic completeCycle;
	logic wrStrobe;
	logic wordWrite;
	logic byteWrite;
	logic [7:0] keyByte;
	logic [7:0] dataByte;
	logic modeEnabled;
	logic mapped;
	logic [31:0] next_prdata;

	function automatic logic isHit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
		isHit = (a == ofs);
	endfunction

	function automatic logic modeLegal(input logic [7:0] v);
		modeLegal = (v == MODE_IDLE) || (v == MODE_ROM_0) || (v == MODE_ROM_1) ||
			(v == MODE_ROM_2) || (v == MODE_ROM_3) || (v == MODE_ROM_4) ||
			(v == MODE_ROM_5) || (v == MODE_EEPROM);
	endfunction

	// Pin levels pass three flops; the filtered level moves only when stages two and three agree.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			romSync <= 3'h0;
			stbySync <= 3'h0;
			romEnabled <= 1'b0;
			standby <= 1'b0;
		end else begin
			romSync <= {romSync[1:0], romEnabledPin};
			stbySync <= {stbySync[1:0], standbyPin};
			if (romSync[1] == romSync[2]) begin
				romEnabled <= romSync[2];
			end
			if (stbySync[1] == stbySync[2]) begin
				standby <= stbySync[2];
			end
		end
	end

	assign accessCycle = apbReq.psel && apbReq.penable && !pready;
	// Writes land at the edge where the master sees pready high, never earlier.
	assign completeCycle = apbReq.psel && apbReq.penable && pready;
	assign wrStrobe = completeCycle && apbReq.pwrite && romEnabled;
	assign wordWrite = wrStrobe && (apbReq.pstrb[1:0] == 2'h3);
	assign byteWrite = wrStrobe && (apbReq.pstrb[1:0] != 2'h3);
	assign keyByte = apbReq.pwdata[15:8];
	assign dataByte = apbReq.pwdata[7:0];
	assign modeEnabled = wordWrite && controllerReadyFlag && (keyByte == KEY_MODE_ENTRY);
	assign mapped = isHit(apbReq.paddr, OFS_PE_EN_LO) || isHit(apbReq.paddr, OFS_PE_EN_HI) ||
		isHit(apbReq.paddr, OFS_MODE_ENTRY) || isHit(apbReq.paddr, OFS_BC_CTRL) ||
		isHit(apbReq.paddr, OFS_BC_RESULT) || isHit(apbReq.paddr, OFS_MAT_SEL);

	// Block enables: key-checked word writes only; a byte write cannot carry a key.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			peEnLo <= RST_BYTE;
			peEnHi <= RST_BYTE;
		end else if (standby) begin
			peEnLo <= RST_BYTE;
			peEnHi <= RST_BYTE;
		end else begin
			if (wordWrite && isHit(apbReq.paddr, OFS_PE_EN_LO) && keyByte == KEY_PE_EN_LO) begin
				peEnLo <= dataByte;
			end
			if (wordWrite && isHit(apbReq.paddr, OFS_PE_EN_HI) && keyByte == KEY_PE_EN_HI) begin
				peEnHi <= dataByte;
			end
		end
	end

	// MAT select.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			infoSel <= 1'b0;
		end else if (standby) begin
			infoSel <= 1'b0;
		end else if (wordWrite && isHit(apbReq.paddr, OFS_MAT_SEL) && keyByte == KEY_MAT_SEL) begin
			infoSel <= dataByte[INFO_SEL_POS];
		end
	end

	// Mode entry: loads only from zero; any other write that reaches it drops it to zero, except a keyed word write with controllerReadyFlag low, which leaves it.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			modeEntry <= MODE_IDLE;
		end else if (standby || controllerSoftReset) begin
			modeEntry <= MODE_IDLE;
		end else if (isHit(apbReq.paddr, OFS_MODE_ENTRY)) begin
			if (byteWrite) begin
				modeEntry <= MODE_IDLE;
			end else if (wordWrite && keyByte != KEY_MODE_ENTRY) begin
				modeEntry <= MODE_IDLE;
			end else if (modeEnabled && modeEntry != MODE_IDLE) begin
				modeEntry <= MODE_IDLE;
			end else if (modeEnabled) begin
				modeEntry <= dataByte;
			end
		end
	end

	// Blank-check control and result; the result is set only by the command unit.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			bcOffset <= RST_BC_OFFSET;
			blank_check_size <= 1'b0;
			notBlank <= 1'b0;
		end else if (standby || controllerSoftReset) begin
			bcOffset <= RST_BC_OFFSET;
			blank_check_size <= 1'b0;
			notBlank <= 1'b0;
		end else begin
			if (wrStrobe && isHit(apbReq.paddr, OFS_BC_CTRL)) begin
				if (apbReq.pstrb[1]) begin
					bcOffset[9:5] <= apbReq.pwdata[BC_OFFSET_MSB:8];
				end
				if (apbReq.pstrb[0]) begin
					bcOffset[4:0] <= apbReq.pwdata[7:BC_OFFSET_LSB];
					blank_check_size <= apbReq.pwdata[BC_SIZE_POS];
				end
			end
			if (blankCheckDone) begin
				notBlank <= blankCheckNotBlank;
			end
		end
	end

	// Register-driven status toward the controller.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			blockPeAllow <= 16'h0000;
			eepromPeSelect <= 1'b0;
			romPeSelect <= 7'h00;
			illegalCommandError <= 1'b0;
			commandLocked <= 1'b0;
			blankCheckSize <= 1'b0;
			blankCheckStart <= 32'h0000_0000;
			infoAreaSelect <= 1'b0;
		end else begin
			blockPeAllow <= {peEnHi, peEnLo};
			eepromPeSelect <= modeEntry[EEPROM_PE_SELECT_POS];
			romPeSelect <= modeEntry[6:0];
			illegalCommandError <= !modeLegal(modeEntry);
			commandLocked <= !modeLegal(modeEntry);
			blankCheckSize <= blank_check_size;
			blankCheckStart <= peCmd.blockBase + {19'h0, bcOffset, 3'h0};
			infoAreaSelect <= infoSel;
		end
	end

	// Program/erase commands are checked against the block enables; only the grant also checks the MAT choice (infoSel low).
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			peGrant <= 1'b0;
			peProtectError <= 1'b0;
		end else begin
			peGrant <= peCmd.valid && peCmd.isPe && !infoSel && blockPeAllow[peCmd.block];
			peProtectError <= peCmd.valid && peCmd.isPe && !blockPeAllow[peCmd.block];
		end
	end

	always_comb begin
		next_prdata = 32'h0000_0000;
		if (romEnabled) begin
			if (isHit(apbReq.paddr, OFS_PE_EN_LO)) begin
				next_prdata[7:0] = peEnLo;
			end else if (isHit(apbReq.paddr, OFS_PE_EN_HI)) begin
				next_prdata[7:0] = peEnHi;
			end else if (isHit(apbReq.paddr, OFS_MODE_ENTRY)) begin
				next_prdata[7:0] = modeEntry;
			end else if (isHit(apbReq.paddr, OFS_BC_CTRL)) begin
				next_prdata[BC_OFFSET_MSB:BC_OFFSET_LSB] = bcOffset;
				next_prdata[BC_SIZE_POS] = blank_check_size;
			end else if (isHit(apbReq.paddr, OFS_BC_RESULT)) begin
				next_prdata[NOT_BLANK_POS] = notBlank;
			end else if (isHit(apbReq.paddr, OFS_MAT_SEL)) begin
				next_prdata[INFO_SEL_POS] = infoSel;
			end
		end
	end

	// One wait state: the answer is registered in the first access cycle.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= accessCycle;
			pslverr <= accessCycle && !mapped;
			if (accessCycle && !apbReq.pwrite) begin
				prdata <= next_prdata;
			end
		end
	end
endmodule
`default_nettype wire

// ===== dv/epg_regs_props.sv
`default_nettype none
module epg_regs_props
	import epg_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire epg_pkg::epg_apb_req_s apbReq,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic standbyPin,
	input wire logic controllerSoftReset,
	input wire epg_pkg::epg_cmd_s peCmd,
	input wire logic [15:0] blockPeAllow,
	input wire logic eepromPeSelect,
	input wire logic [6:0] romPeSelect,
	input wire logic illegalCommandError,
	input wire logic commandLocked,
	input wire logic blankCheckSize,
	input wire logic infoAreaSelect,
	input wire logic peGrant,
	input wire logic peProtectError
);
	logic peReq;
	logic allowHit;
	logic denyHit;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// Enables seen at the ports lag the registers; the bench never moves them near a command.
	assign peReq = peCmd.valid && peCmd.isPe && !infoAreaSelect;
	assign allowHit = peReq && blockPeAllow[peCmd.block];
	assign denyHit = peReq && !blockPeAllow[peCmd.block];
	rdy_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
	rdy_wait_a: assert property (apbReq.psel && apbReq.penable && !pready |=> pready)
		else $error("access not answered after one wait state");
	err_rdy_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
	lock_err_a: assert property (commandLocked == illegalCommandError)
		else $error("command lock differs from illegal flag");
	mode_illegal_a: assert property (eepromPeSelect && romPeSelect != 7'h00 |-> ##[0:1] illegalCommandError)
		else $error("two mode bits set without illegal flag");
	grant_cause_a: assert property (peGrant |-> $past(allowHit))
		else $error("grant without enabled block in data area");
	deny_cause_a: assert property (peProtectError |-> $past(denyHit))
		else $error("protect error without disabled block");
	deny_seen_a: assert property (denyHit |=> peProtectError)
		else $error("disabled block command not flagged");
	stby_clear_a: assert property ($rose(standbyPin) ##1 standbyPin[*6] |-> blockPeAllow == 16'h0000 && !infoAreaSelect)
		else $error("standby did not clear enables");
	soft_clear_a: assert property (controllerSoftReset[*3] |-> !eepromPeSelect && !blankCheckSize)
		else $error("soft reset did not clear mode and check size");
endmodule
bind epg_regs epg_regs_props i_epg_regs_props (.sys_clk(sys_clk), .sys_rst(sys_rst),
	.apbReq(apbReq), .pready(pready), .pslverr(pslverr), .standbyPin(standbyPin),
	.controllerSoftReset(controllerSoftReset), .peCmd(peCmd), .blockPeAllow(blockPeAllow),
	.eepromPeSelect(eepromPeSelect), .romPeSelect(romPeSelect),
	.illegalCommandError(illegalCommandError), .commandLocked(commandLocked),
	.blankCheckSize(blankCheckSize), .infoAreaSelect(infoAreaSelect), .peGrant(peGrant),
	.peProtectError(peProtectError));
`default_nettype wire

// ===== dv/testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import epg_pkg::*;
	logic sys_clk = 0, sys_rst = 1, romEn = 1, stby = 0, rdy = 1, srst = 0, bcDone = 0, bcNb = 0;
	epg_apb_req_s req = '0;
	epg_cmd_s cmd = '0;
	logic [31:0] prdata, bcStart, rd;
	logic pready, pslverr, err, eSel, ilg, lck, blank_check_size, info, grant, perr;
	logic [15:0] allow;
	logic [6:0] romSel;
	logic [7:0] modes [7] = '{MODE_ROM_0, MODE_ROM_1, MODE_ROM_2, MODE_ROM_3, MODE_ROM_4,
		MODE_ROM_5, MODE_EEPROM};
	int failures = 0, num_checks = 0;
	epg_regs i_epg_regs (.sys_clk(sys_clk), .sys_rst(sys_rst), .apbReq(req), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .romEnabledPin(romEn), .standbyPin(stby),
		.controllerReadyFlag(rdy), .controllerSoftReset(srst), .blankCheckDone(bcDone),
		.blankCheckNotBlank(bcNb), .peCmd(cmd), .blockPeAllow(allow), .eepromPeSelect(eSel),
		.romPeSelect(romSel), .illegalCommandError(ilg), .commandLocked(lck),
		.blankCheckSize(blank_check_size), .blankCheckStart(bcStart), .infoAreaSelect(info),
		.peGrant(grant), .peProtectError(perr));
	initial forever #10 sys_clk = ~sys_clk;
	task give_verdict;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		req <= '{1'b1, 1'b0, w, a, d, s};
		@(posedge sys_clk);
		req.penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		req <= '0;
		@(posedge sys_clk);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 4'h3);
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0, 4'h3);
		chk(rd, exp);
	endtask
	task pe(input logic [3:0] b, input logic g, input logic e);
		cmd <= '{1'b1, 1'b1, b, 32'h0};
		@(posedge sys_clk);
		cmd.valid <= 1'b0;
		#1;
		chk(grant, g);
		chk(perr, e);
		@(posedge sys_clk);
	endtask
	initial begin
		#200000;
		failures++;
		give_verdict();
	end
	initial begin
		repeat (3) @(posedge sys_clk);
		sys_rst <= 0;
		repeat (5) @(posedge sys_clk);
		for (int i = 0; i < 6; i++) rdc(12'(4 * i), 32'h0);
		wr(OFS_PE_EN_LO, 32'h1ea5);
		rdc(OFS_PE_EN_LO, 32'h00a5);
		apb(1'b1, OFS_PE_EN_LO, 32'h1eff, 4'h1);
		wr(OFS_PE_EN_LO, 32'he1ff);
		rdc(OFS_PE_EN_LO, 32'h00a5);
		wr(OFS_PE_EN_HI, 32'h1eff);
		wr(OFS_PE_EN_HI, 32'he13c);
		rdc(OFS_PE_EN_HI, 32'h003c);
		chk(allow, 32'h3ca5);
		$display("enable test done");
		rdy <= 0;
		wr(OFS_MODE_ENTRY, 32'haa80);
		rdc(OFS_MODE_ENTRY, 32'h0);
		rdy <= 1;
		wr(OFS_MODE_ENTRY, 32'haa80);
		rdc(OFS_MODE_ENTRY, 32'h0080);
		chk(eSel, 1'b1);
		wr(OFS_MODE_ENTRY, 32'haa80);
		rdc(OFS_MODE_ENTRY, 32'h0);
		wr(OFS_MODE_ENTRY, 32'haa80);
		apb(1'b1, OFS_MODE_ENTRY, 32'haa80, 4'h1);
		rdc(OFS_MODE_ENTRY, 32'h0);
		wr(OFS_MODE_ENTRY, 32'haa80);
		wr(OFS_MODE_ENTRY, 32'h5580);
		rdc(OFS_MODE_ENTRY, 32'h0);
		wr(OFS_MODE_ENTRY, 32'haa03);
		rdc(OFS_MODE_ENTRY, 32'h0003);
		chk(ilg & lck, 1'b1);
		wr(OFS_MODE_ENTRY, 32'haa00);
		foreach (modes[i]) begin
			wr(OFS_MODE_ENTRY, {24'h0000aa, modes[i]});
			rdc(OFS_MODE_ENTRY, {24'h0, modes[i]});
			chk(ilg | lck, 1'b0);
			wr(OFS_MODE_ENTRY, 32'haa00);
		end
		$display("mode entry test done");
		wr(OFS_BC_CTRL, 32'hffff);
		rdc(OFS_BC_CTRL, 32'h1ff9);
		chk(blank_check_size, 1'b1);
		srst <= 1;
		repeat (4) @(posedge sys_clk);
		srst <= 0;
		rdc(OFS_BC_CTRL, 32'h0);
		wr(OFS_BC_CTRL, 32'h0028);
		cmd <= '{1'b1, 1'b0, 4'h3, 32'h1000};
		@(posedge sys_clk);
		cmd.valid <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk(bcStart, 32'h1028);
		chk(blank_check_size, 1'b0);
		bcDone <= 1;
		bcNb <= 1;
		@(posedge sys_clk);
		bcDone <= 0;
		wr(OFS_BC_RESULT, 32'h0);
		rdc(OFS_BC_RESULT, 32'h1);
		$display("blank check test done");
		wr(OFS_MAT_SEL, 32'hb301);
		rdc(OFS_MAT_SEL, 32'h1);
		pe(4'h2, 1'b0, 1'b0);
		apb(1'b1, OFS_MAT_SEL, 32'hb300, 4'h1);
		rdc(OFS_MAT_SEL, 32'h1);
		wr(OFS_MAT_SEL, 32'hb300);
		pe(4'h2, 1'b1, 1'b0);
		pe(4'h1, 1'b0, 1'b1);
		pe(4'ha, 1'b1, 1'b0);
		pe(4'h8, 1'b0, 1'b1);
		apb(1'b0, 12'h018, 32'h0, 4'h3);
		chk(err, 1'b1);
		$display("command test done");
		romEn <= 0;
		repeat (5) @(posedge sys_clk);
		rdc(OFS_PE_EN_LO, 32'h0);
		stby <= 1;
		repeat (8) @(posedge sys_clk);
		stby <= 0;
		wr(OFS_PE_EN_LO, 32'h1eff);
		romEn <= 1;
		repeat (5) @(posedge sys_clk);
		rdc(OFS_PE_EN_LO, 32'h0);
		rdc(OFS_MAT_SEL, 32'h0);
		$display("standby test done");
		give_verdict();
	end
endmodule
`default_nettype wire
